// ==== design/mpt_regs.vh ====
`ifndef MPT_REGS_VH
`define MPT_REGS_VH

// Register byte offsets on the APB slave.
`define MPT_OFS_CTL0 8'h00
`define MPT_OFS_CTL1 8'h04
`define MPT_OFS_PERIOD 8'h08
`define MPT_OFS_DEAD 8'h0C
`define MPT_OFS_DUTY0 8'h10
`define MPT_OFS_DUTY5 8'h24
`define MPT_OFS_STAT 8'h28

// Control zero fields.
`define MPT_CTL0_EN 0
`define MPT_CTL0_READY 1
`define MPT_CTL0_CENTER 2

// Control one fields.
`define MPT_CTL1_COUNT_CLOCK_DIVIDER_LSB 0
`define MPT_CTL1_RF_LSB 2
`define MPT_CTL1_INDEP_LSB 4
`define MPT_CTL1_POL_LSB 7

// Status fields.
`define MPT_STAT_CNT_LSB 0
`define MPT_STAT_DIR 12
`define MPT_STAT_READY 13
`define MPT_STAT_COUNT_CLOCK_DIVIDER_LSB 14
`define MPT_STAT_PINS_LSB 16

// Reset values.
`define MPT_RST_PERIOD 12'hFFF
`define MPT_RST_DUTY 16'h0000
`define MPT_RST_DEAD 8'h00

`endif

// ==== design/mpt_pair.v ====
`timescale 1ns/100ps
// One output pair: applies dead time between the high and low requests.
// In independent operation the requests pass straight to the registered outputs.
module mpt_pair #(
	parameter DW = 8
) (
	input wire clk,
	input wire srst,
	input wire comp,
	input wire [DW-1:0] dead,
	input wire h_req,
	input wire l_req,
	output reg h_act,
	output reg l_act
);
	// Cycles each request has been continuously high, saturating.
	reg [DW-1:0] h_cnt_r;
	reg [DW-1:0] l_cnt_r;
	wire [DW-1:0] cnt_max = {DW{1'b1}};

	// Count how long each request has been asserted.
	always @(posedge clk) begin
		if (srst) begin
			h_cnt_r <= {DW{1'b0}};
			l_cnt_r <= {DW{1'b0}};
		end else begin
			h_cnt_r <= !h_req ? {DW{1'b0}} : (h_cnt_r == cnt_max ? h_cnt_r : h_cnt_r + 1'b1);
			l_cnt_r <= !l_req ? {DW{1'b0}} : (l_cnt_r == cnt_max ? l_cnt_r : l_cnt_r + 1'b1);
		end
	end

	// A side turns on only after its request has stood for the dead time with the partner's request down.
	// Turn-off is immediate, so the gap between the two sides equals the dead time and a zero dead time
	// costs no active time; the two requests are exclusive here, so the outputs can never overlap.
	always @(posedge clk) begin
		if (srst) begin
			h_act <= 1'b0;
			l_act <= 1'b0;
		end else if (!comp) begin
			h_act <= h_req;
			l_act <= l_req;
		end else begin
			h_act <= h_req && (h_cnt_r >= dead) && !l_req;
			l_act <= l_req && (l_cnt_r >= dead) && !h_req;
		end
	end
endmodule

// ==== design/mpt_timebase.v ====
`timescale 1ns/100ps
// Functional notes
// - High option bit sets high-side off-state, polarity.
// - Low option bit sets low-side off-state, polarity.
// - Off-state equals option bit; active is opposite.
// - Option bits fixed at reset, software cannot change.
// - Motor enable off: all six pins undriven.
// - Motor enable on: undriven in reset, then off-state.
// - Duty and prescale writes buffered until reload.
// - Reload every 1, 2, 4 or 8 periods.
// - Buffers transfer at first reload after ready.
// - Two-bit prescale divides clock by 1,2,4,8.
// - Prescale ratio changes only at reload events.
// - Edge mode: 12-bit up counter wraps to zero.
// - Edge period is prescale times reload value.
// - Center mode counts up then down; double period.
// - Each pair independent or complementary, selectable.
// - Complementary pairs get dead time, never overlap.
// - Duty and dead time set active time.
// - Signed 16-bit duty; zero or less stays inactive.
// - Polarity clear: high starts on, low opposite.
`include "mpt_regs.vh"
module mpt_timebase #(
	parameter CW = 12,
	parameter DW = 8
) (
	input wire clk,
	input wire srst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output reg pslverr,
	input wire high_side_offstate_option,
	input wire low_side_offstate_option,
	input wire motor_output_enable_option,
	output wire high_side_out_0,
	output wire high_side_out_0_oe,
	output wire high_side_out_1,
	output wire high_side_out_1_oe,
	output wire high_side_out_2,
	output wire high_side_out_2_oe,
	output wire low_side_out_0,
	output wire low_side_out_0_oe,
	output wire low_side_out_1,
	output wire low_side_out_1_oe,
	output wire low_side_out_2,
	output wire low_side_out_2_oe
);
	// Option bit synchronisers; the first stage feeds only the second.
	reg [2:0] opt_s1_r;
	reg [2:0] opt_s2_r;
	// Option values sampled while reset is applied, frozen after release.
	reg opt_hi_r;
	reg opt_lo_r;
	reg opt_en_r;
	// Pin drive enable, low through reset.
	reg oe_r;
	// Registered pin levels, high side in bits 2:0, low side in bits 5:3.
	reg [5:0] pin_r;

	// Software visible control.
	reg enable_r;
	reg ready_r;
	reg center_r;
	reg [1:0] rf_sel_r;
	reg [2:0] indep_r;
	reg [2:0] pol_r;
	reg [DW-1:0] dead_r;
	// Shadow copies written by software.
	reg [1:0] count_clock_divider_sh_r;
	reg [CW-1:0] per_sh_r;
	reg [15:0] duty_sh_r [0:5];
	// Active copies used by the counter and comparators.
	reg [1:0] count_clock_divider_a_r;
	reg [CW-1:0] per_a_r;
	reg [15:0] duty_a_r [0:5];

	// Time base state.
	reg [2:0] pre_cnt_r;
	reg [CW-1:0] cnt_r;
	reg dir_down_r;
	reg [2:0] rf_cnt_r;

	integer i;

	// APB decode.
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire setup = psel && !penable;
	wire duty_hit = (paddr >= `MPT_OFS_DUTY0) && (paddr <= `MPT_OFS_DUTY5) && (paddr[1:0] == 2'b00);
	wire [7:0] duty_ofs = paddr - `MPT_OFS_DUTY0;
	wire [2:0] duty_idx = duty_ofs[4:2];

	// The slave never inserts wait states.
	assign pready = acc;

	// Prescale and reload-frequency limits.
	wire [3:0] pre_lim = (4'h1 << count_clock_divider_a_r) - 4'h1;
	wire [3:0] rf_lim = (4'h1 << rf_sel_r) - 4'h1;
	wire tick = (pre_cnt_r == pre_lim[2:0]);
	// A zero period is treated as one so the counter cannot stall.
	wire [CW-1:0] per_eff = (per_a_r == {CW{1'b0}}) ? {{(CW-1){1'b0}}, 1'b1} : per_a_r;
	wire [CW-1:0] per_m1 = per_eff - 1'b1;
	wire [CW-1:0] one = {{(CW-1){1'b0}}, 1'b1};

	// End of period in either counting mode.
	wire pend_edge = tick && (cnt_r >= per_m1);
	wire pend_center = tick && dir_down_r && (cnt_r <= one);
	wire pend = enable_r && (center_r ? pend_center : pend_edge);
	wire reload = pend && (rf_cnt_r == rf_lim[2:0]);
	wire xfer = reload && ready_r;

	// Option bit synchronisers.
	always @(posedge clk) begin
		opt_s1_r <= {motor_output_enable_option, low_side_offstate_option, high_side_offstate_option};
		opt_s2_r <= opt_s1_r;
	end

	// Option values are taken only while reset is held, never from software.
	always @(posedge clk) begin
		if (srst) begin
			opt_hi_r <= opt_s2_r[0];
			opt_lo_r <= opt_s2_r[1];
			opt_en_r <= opt_s2_r[2];
		end
	end

	// Pins float through reset and are driven after release only if enabled.
	always @(posedge clk) begin
		if (srst) begin
			oe_r <= 1'b0;
		end else begin
			oe_r <= opt_en_r;
		end
	end

	// APB register writes and the buffered transfer.
	always @(posedge clk) begin
		if (srst) begin
			enable_r <= 1'b0;
			ready_r <= 1'b0;
			center_r <= 1'b0;
			rf_sel_r <= 2'h0;
			indep_r <= 3'h0;
			pol_r <= 3'h0;
			dead_r <= `MPT_RST_DEAD;
			count_clock_divider_sh_r <= 2'h0;
			per_sh_r <= `MPT_RST_PERIOD;
			count_clock_divider_a_r <= 2'h0;
			per_a_r <= `MPT_RST_PERIOD;
			for (i = 0; i < 6; i = i + 1) begin
				duty_sh_r[i] <= `MPT_RST_DUTY;
				duty_a_r[i] <= `MPT_RST_DUTY;
			end
		end else begin
			// Transfer first so a same-cycle ready write can set it again.
			if (xfer) begin
				count_clock_divider_a_r <= count_clock_divider_sh_r;
				per_a_r <= per_sh_r;
				for (i = 0; i < 6; i = i + 1) begin
					duty_a_r[i] <= duty_sh_r[i];
				end
				ready_r <= 1'b0;
			end
			if (wr) begin
				case (paddr)
					`MPT_OFS_CTL0: begin
						enable_r <= pwdata[`MPT_CTL0_EN];
						center_r <= pwdata[`MPT_CTL0_CENTER];
						// Writing zero does not withdraw a pending update.
						if (pwdata[`MPT_CTL0_READY]) begin
							ready_r <= 1'b1;
						end
					end
					`MPT_OFS_CTL1: begin
						count_clock_divider_sh_r <= pwdata[`MPT_CTL1_COUNT_CLOCK_DIVIDER_LSB +: 2];
						rf_sel_r <= pwdata[`MPT_CTL1_RF_LSB +: 2];
						indep_r <= pwdata[`MPT_CTL1_INDEP_LSB +: 3];
						pol_r <= pwdata[`MPT_CTL1_POL_LSB +: 3];
					end
					`MPT_OFS_PERIOD: begin
						per_sh_r <= pwdata[CW-1:0];
					end
					`MPT_OFS_DEAD: begin
						dead_r <= pwdata[DW-1:0];
					end
					default: begin
						// Duty writes land in the shadow only.
						if (duty_hit) begin
							duty_sh_r[duty_idx] <= pwdata[15:0];
						end
					end
				endcase
			end
		end
	end

	// Read data and error flag are captured in the setup cycle.
	always @(posedge clk) begin
		if (srst) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup) begin
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			case (paddr)
				`MPT_OFS_CTL0: begin
					prdata[`MPT_CTL0_EN] <= enable_r;
					prdata[`MPT_CTL0_READY] <= ready_r;
					prdata[`MPT_CTL0_CENTER] <= center_r;
				end
				`MPT_OFS_CTL1: begin
					prdata[9:0] <= {pol_r, indep_r, rf_sel_r, count_clock_divider_sh_r};
				end
				`MPT_OFS_PERIOD: begin
					prdata[CW-1:0] <= per_sh_r;
				end
				`MPT_OFS_DEAD: begin
					prdata[DW-1:0] <= dead_r;
				end
				`MPT_OFS_STAT: begin
					// Status shows the live counter and active settings.
					prdata[`MPT_STAT_CNT_LSB +: CW] <= cnt_r;
					prdata[`MPT_STAT_DIR] <= dir_down_r;
					prdata[`MPT_STAT_READY] <= ready_r;
					prdata[`MPT_STAT_COUNT_CLOCK_DIVIDER_LSB +: 2] <= count_clock_divider_a_r;
					prdata[`MPT_STAT_PINS_LSB +: 6] <= pin_r;
				end
				default: begin
					if (duty_hit) begin
						prdata[15:0] <= duty_sh_r[duty_idx];
					end else begin
						pslverr <= 1'b1;
					end
				end
			endcase
		end
	end

	// Prescaler: one count tick every 1, 2, 4 or 8 system clocks.
	always @(posedge clk) begin
		if (srst || !enable_r) begin
			pre_cnt_r <= 3'h0;
		end else if (tick) begin
			pre_cnt_r <= 3'h0;
		end else begin
			pre_cnt_r <= pre_cnt_r + 3'h1;
		end
	end

	// Master counter in edge or center alignment.
	always @(posedge clk) begin
		if (srst || !enable_r) begin
			cnt_r <= {CW{1'b0}};
			dir_down_r <= 1'b0;
		end else if (tick) begin
			if (!center_r) begin
				dir_down_r <= 1'b0;
				// Count 0 to period-1 so the period is prescale times reload.
				if (cnt_r >= per_m1) begin
					cnt_r <= {CW{1'b0}};
				end else begin
					cnt_r <= cnt_r + one;
				end
			end else if (!dir_down_r) begin
				// Turn at the reload value, then fall back to zero.
				if (cnt_r >= per_eff) begin
					dir_down_r <= 1'b1;
					cnt_r <= cnt_r - one;
				end else begin
					cnt_r <= cnt_r + one;
				end
			end else begin
				if (cnt_r <= one) begin
					cnt_r <= {CW{1'b0}};
					dir_down_r <= 1'b0;
				end else begin
					cnt_r <= cnt_r - one;
				end
			end
		end
	end

	// Period counter for the reload frequency.
	always @(posedge clk) begin
		if (srst || !enable_r) begin
			rf_cnt_r <= 3'h0;
		end else if (reload) begin
			rf_cnt_r <= 3'h0;
		end else if (pend) begin
			rf_cnt_r <= rf_cnt_r + 3'h1;
		end
	end

	// Comparators: a positive duty is active while the count is below it.
	reg [5:0] pos;
	reg [5:0] below;
	integer k;
	always @* begin
		for (k = 0; k < 6; k = k + 1) begin
			pos[k] = !duty_a_r[k][15] && (duty_a_r[k] != 16'h0000);
			below[k] = ({4'h0, cnt_r} < duty_a_r[k]);
		end
	end

	// Requests per pair before dead time.
	wire [2:0] h_req;
	wire [2:0] l_req;
	wire [2:0] h_act;
	wire [2:0] l_act;

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : pair
			// High side starts on unless the polarity bit swaps it.
			assign h_req[g] = pos[g] && (below[g] ^ pol_r[g]);
			// Low side follows its own duty, or is the inverse of the high side.
			assign l_req[g] = indep_r[g] ? (pos[g+3] && (below[g+3] ^ !pol_r[g])) : !h_req[g];
			mpt_pair #(
				.DW(DW)
			) u_pair (
				.clk(clk),
				.srst(srst),
				.comp(!indep_r[g]),
				.dead(dead_r),
				.h_req(h_req[g]),
				.l_req(l_req[g]),
				.h_act(h_act[g]),
				.l_act(l_act[g])
			);
		end
	endgenerate

	// Pin levels: off-state equals the option bit, active state is its inverse.
	always @(posedge clk) begin
		if (srst) begin
			pin_r <= 6'h00;
		end else if (!enable_r) begin
			pin_r <= {{3{opt_lo_r}}, {3{opt_hi_r}}};
		end else begin
			pin_r <= {l_act ^ {3{opt_lo_r}}, h_act ^ {3{opt_hi_r}}};
		end
	end

	// Pin outputs with a shared drive enable.
	assign high_side_out_0 = pin_r[0];
	assign high_side_out_1 = pin_r[1];
	assign high_side_out_2 = pin_r[2];
	assign low_side_out_0 = pin_r[3];
	assign low_side_out_1 = pin_r[4];
	assign low_side_out_2 = pin_r[5];
	assign high_side_out_0_oe = oe_r;
	assign high_side_out_1_oe = oe_r;
	assign high_side_out_2_oe = oe_r;
	assign low_side_out_0_oe = oe_r;
	assign low_side_out_1_oe = oe_r;
	assign low_side_out_2_oe = oe_r;
endmodule

// ==== bench/mpt_timebase_chk.sv ====
`timescale 1ns/100ps
// Bus, option and pin checks at the timebase ports.
module mpt_timebase_chk (
	input wire clk,
	input wire srst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire high_side_offstate_option,
	input wire low_side_offstate_option,
	input wire motor_output_enable_option,
	input wire high_side_out_0,
	input wire high_side_out_0_oe,
	input wire low_side_out_0,
	input wire low_side_out_0_oe
);
	reg hi_r, lo_r, en_r, ind_r; // Options seen in reset; pair zero independent.
	wire bad = (paddr > 8'h28) || (paddr[1:0] != 2'b00); // Above the map or not word aligned.
	// Options count only while reset is held, as in the device.
	always @(posedge clk) begin
		if (srst) begin
			hi_r <= high_side_offstate_option;
			lo_r <= low_side_offstate_option;
			en_r <= motor_output_enable_option;
			ind_r <= 1'b0;
		end else if (psel && penable && pwrite && paddr == 8'h04) begin
			ind_r <= pwdata[4];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence setup_s(b); psel && !penable && b ##1 penable; endsequence
	sequence up_s; $fell(srst) ##1 high_side_out_0_oe; endsequence
	pready_a: assert property (pready == (psel && penable)) else $error("Bad ready.");
	err_unmapped_a: assert property (setup_s(bad) |-> pslverr && prdata == 32'h0) else $error("No error.");
	ok_mapped_a: assert property (setup_s(!bad) |-> !pslverr) else $error("False error.");
	oe_reset_a: assert property ($fell(srst) |-> !high_side_out_0_oe)
		else $error("Driven in reset.");
	oe_enable_a: assert property ($past(!srst) |-> high_side_out_0_oe == en_r)
		else $error("Bad enable.");
	offstate_level_a: assert property (up_s |=> high_side_out_0 == hi_r && low_side_out_0 == lo_r)
		else $error("Bad off level.");
	oe_equal_a: assert property (high_side_out_0_oe == low_side_out_0_oe) else $error("Enables differ.");
	no_overlap_a: assert property (!ind_r && high_side_out_0_oe |->
		high_side_out_0 == hi_r || low_side_out_0 == lo_r) else $error("Pair overlap.");
endmodule

// ==== bench/mpt_gate_drv.sv ====
`timescale 1ns/100ps
// Gate drive for three inverter legs; the board pulls an undriven pin to its off level.
module mpt_gate_drv (
	input wire clk,
	input wire hi_off,
	input wire lo_off,
	input wire [2:0] hs,
	input wire [2:0] hs_oe,
	input wire [2:0] ls,
	input wire [2:0] ls_oe,
	output wire [2:0] gate_h,
	output wire [2:0] gate_l,
	output reg [7:0] shoot = 8'h00
);
	// A gate is on when its pin sits away from the off level.
	assign gate_h = ((hs & hs_oe) | ({3{hi_off}} & ~hs_oe)) ^ {3{hi_off}};
	assign gate_l = ((ls & ls_oe) | ({3{lo_off}} & ~ls_oe)) ^ {3{lo_off}};
	// Both gates of a leg on at once would short the supply, so count such cycles.
	always @(posedge clk) begin
		if (|(gate_h & gate_l)) begin
			shoot <= shoot + 8'h01;
		end
	end
endmodule

// ==== bench/mpt_timebase_bench.sv ====
`timescale 1ns/100ps
// Row table of timing cases, then odd cases.
module mpt_timebase_bench;
	typedef struct {logic [1:0] pr; logic ctr; logic [11:0] per; logic [15:0] dc; int tp; int tw;} mpt_row_t;
	// Settings beside period and high time in clocks; tw 0 is not checked.
	mpt_row_t rows [5] = '{'{2'h1, 1'b0, 12'h007, 16'h0002, 14, 4}, '{2'h3, 1'b0, 12'h003, 16'h0001, 24, 8},
		'{2'h2, 1'b1, 12'h005, 16'h0002, 40, 0}, '{2'h0, 1'b1, 12'h006, 16'h0003, 12, 0},
		'{2'h0, 1'b0, 12'h00A, 16'h0003, 10, 3}};
	logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, er;
	logic hi_o = 1'b1, lo_o = 1'b0, en_o = 1'b1, hw_hi = 1'b1, hw_lo = 1'b0; // Options and board wiring.
	wire pready, pslverr;
	wire [31:0] prdata;
	wire [2:0] hs, hs_oe, ls, ls_oe, gh, gl;
	wire [7:0] shoot;
	integer num_errors = 0, n_compared = 0, cyc = 0, w, p, t0, i, k;
	mpt_timebase dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .high_side_offstate_option(hi_o),
		.low_side_offstate_option(lo_o), .motor_output_enable_option(en_o), .high_side_out_0(hs[0]),
		.high_side_out_0_oe(hs_oe[0]), .high_side_out_1(hs[1]), .high_side_out_1_oe(hs_oe[1]),
		.high_side_out_2(hs[2]), .high_side_out_2_oe(hs_oe[2]), .low_side_out_0(ls[0]), .low_side_out_0_oe(ls_oe[0]),
		.low_side_out_1(ls[1]), .low_side_out_1_oe(ls_oe[1]), .low_side_out_2(ls[2]), .low_side_out_2_oe(ls_oe[2]));
	mpt_gate_drv drv_u (.clk(clk), .hi_off(hw_hi), .lo_off(hw_lo), .hs(hs), .hs_oe(hs_oe), .ls(ls), .ls_oe(ls_oe),
		.gate_h(gh), .gate_l(gl), .shoot(shoot));
	// Clock and cycle count.
	initial forever #10 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One APB transfer; the request holds until pready is seen high.
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		integer n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50) begin
			num_errors++;
			$display("MISMATCH t=%0t no ready", $time);
		end
		rd = prdata;
		er = {31'h0, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Polls status until the ready flag drops.
	task wait_rdy;
		integer n;
		n = 0;
		rd = 32'h2000;
		while (rd[13] !== 1'b0 && n < 3000) begin
			apb(1'b0, 8'h28, 32'h0);
			n++;
		end
		chk({31'h0, rd[13]}, 32'h0);
	endtask
	task rise(inout integer c);
		while (gh[0] !== 1'b0 && c < 9000) begin @(posedge clk); c++; end
		while (gh[0] !== 1'b1 && c < 9000) begin @(posedge clk); c++; end
	endtask
	// High time and period of the first high gate, from one rise to the next.
	task meas(output integer hw, output integer pp);
		pp = 0;
		rise(pp);
		hw = 0;
		pp = 0;
		while (gh[0] === 1'b1 && hw < 9000) begin @(posedge clk); hw++; end
		pp = hw;
		rise(pp);
	endtask
	task do_reset;
		srst <= 1'b1;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
	endtask
	task report_and_stop;
		$display("Compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#600000;
		$display("MISMATCH t=%0t watchdog", $time);
		num_errors++;
		report_and_stop();
	end
	initial begin
		do_reset();
		repeat (3) @(posedge clk);
		chk({26'h0, hs_oe, ls_oe}, 32'h3F);
		chk({26'h0, hs, ls}, 32'h38);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h0FFF);
		hi_o <= 1'b0;
		lo_o <= 1'b1;
		repeat (8) @(posedge clk);
		chk({26'h0, hs, ls}, 32'h38);
		$display("Reset test ended.");
		for (i = 0; i < 5; i++) begin
			apb(1'b1, 8'h04, {30'h0, rows[i].pr});
			apb(1'b1, 8'h08, {20'h0, rows[i].per});
			apb(1'b1, 8'h10, {16'h0, rows[i].dc});
			apb(1'b1, 8'h00, {29'h0, rows[i].ctr, 2'h3});
			wait_rdy();
			apb(1'b0, 8'h28, 32'h0);
			chk({30'h0, rd[15:14]}, {30'h0, rows[i].pr});
			meas(w, p);
			chk(p, rows[i].tp);
			if (rows[i].tw != 0) chk(w, rows[i].tw);
			$display("Row %0d ended.", i);
		end
		// Shadowed values must wait for ready and a reload.
		apb(1'b1, 8'h10, 32'h5);
		apb(1'b1, 8'h04, 32'h1);
		meas(w, p);
		meas(w, p);
		chk(w, 3);
		chk(p, 10);
		apb(1'b1, 8'h00, 32'h3);
		wait_rdy();
		meas(w, p);
		chk(w, 10);
		chk(p, 20);
		$display("Buffer test ended.");
		for (i = 0; i < 4; i++) begin
			apb(1'b1, 8'h04, 32'h1 | (i << 2));
			apb(1'b1, 8'h00, 32'h3);
			wait_rdy();
			t0 = cyc;
			apb(1'b1, 8'h00, 32'h3);
			wait_rdy();
			k = (cyc - t0 >= (20 << i) - 3) && (cyc - t0 <= (20 << i) + 3);
			chk(k, 1);
		end
		$display("Reload test ended.");
		apb(1'b1, 8'h10, 32'h0000FFF0);
		apb(1'b1, 8'h00, 32'h3);
		wait_rdy();
		repeat (4) @(posedge clk);
		k = 0;
		repeat (60) begin @(posedge clk); k += gh[0]; end
		chk(k, 0);
		// Dead time of two clocks comes off the active time, not the period.
		apb(1'b1, 8'h0C, 32'h2);
		apb(1'b1, 8'h10, 32'h3);
		apb(1'b1, 8'h00, 32'h3);
		wait_rdy();
		meas(w, p);
		chk(w, 4);
		chk(p, 20);
		// Polarity set: high side is active from the duty value to the period end.
		apb(1'b1, 8'h04, 32'h8D);
		meas(w, p);
		meas(w, p);
		chk(w, 12);
		// Independent pair zero: the low side follows its own zero duty and stays off.
		apb(1'b1, 8'h04, 32'h1D);
		repeat (4) @(posedge clk);
		k = 0;
		repeat (60) begin @(posedge clk); k += gl[0]; end
		chk(k, 0);
		apb(1'b0, 8'h2C, 32'h0);
		chk(rd, 32'h0);
		chk(er, 32'h1);
		chk({24'h0, shoot}, 32'h0);
		$display("Odd case test ended.");
		en_o <= 1'b0;
		hw_hi <= 1'b0;
		hw_lo <= 1'b1;
		do_reset();
		repeat (3) @(posedge clk);
		chk({26'h0, hs_oe, ls_oe}, 32'h0);
		$display("Disable test ended.");
		report_and_stop();
	end
endmodule
bind mpt_timebase mpt_timebase_chk chk_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.high_side_offstate_option(high_side_offstate_option), .low_side_offstate_option(low_side_offstate_option),
	.motor_output_enable_option(motor_output_enable_option), .high_side_out_0(high_side_out_0),
	.high_side_out_0_oe(high_side_out_0_oe), .low_side_out_0(low_side_out_0), .low_side_out_0_oe(low_side_out_0_oe));
